// ---- verilog/dskst_pkg.sv ----
// Package of constants and types for the diskette result status block
// How it works
// - Access past the final sector of a cylinder sets end-of-cylinder.
// - Unused status bits 6 and 3, and third-register bit 7, read zero.
// - CRC failure on ID or data field sets the data-error flag.
// - Host byte service slower than the rate limit sets the overrun flag.
// - Sector not found on read, write deleted or scan sets no-data.
// - Read ID failure or missing start sector on read cylinder sets no-data.
// - Write-protect seen on write or format sets the not-writable flag.
// - Missing ID mark sets id-mark flag and data-mark flag together.
// - Deleted data mark met on read or scan sets control-mark flag.
// - Error in data read from medium sets data-field-error flag.
// - Medium cylinder unlike requested sets wrong-cylinder with no-data.
// - Differing medium cylinder equal to ff sets the bad-cylinder flag.
// - No data or deleted data mark found sets the missing data-mark flag.
// - Snapshot register shows drive lines, fault down to unit select.
// - DMA request on level 2, interrupt on level 6, never shared.
// - Reduced write current output is the inverse of control bit 0.
// - Up to 80 tracks and fifteen 512-byte sectors per track.
// - MFM; core clock 4.0/4.8/8.0 MHz, precomp 250/208.3/125 ns.
// - Clock switching never makes a high or low phase under 40 ns.
// - Level-6 interrupt rises at the start of the result phase.
package dskst_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [9:0] ADDR_OUTPUT_CTRL = 10'h3f2;
	localparam logic [9:0] ADDR_MAIN_STATE = 10'h3f4;
	localparam logic [9:0] ADDR_CMD_RESULT = 10'h3f5;
	localparam logic [9:0] ADDR_RATE_INPUT = 10'h3f7;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] BAD_CYL_CODE = 8'hff;

	// ****************************************************************
	// Capacity and timing
	// ****************************************************************
	localparam int MAX_TRACKS = 80;
	localparam int MAX_SECTORS = 15;
	localparam int SECTOR_BYTES = 512;
	localparam int CLK_HZ = 50000000;
	localparam int MIN_PHASE_NS = 40;
	localparam int MIN_PHASE_CYC =
		(MIN_PHASE_NS * (CLK_HZ / 1000000) + 999) / 1000;
	// Overrun limits in ns, longest time so rounded down
	localparam int OVR_500_NS = 11000;
	localparam int OVR_300_NS = 17500;
	localparam int OVR_250_NS = 24000;
	localparam int OVR_500_CYC = OVR_500_NS * (CLK_HZ / 1000000) / 1000;
	localparam int OVR_300_CYC = OVR_300_NS * (CLK_HZ / 1000000) / 1000;
	localparam int OVR_250_CYC = OVR_250_NS * (CLK_HZ / 1000000) / 1000;
	// Precompensation in ps, and the same in 20 ns ref cycles, rounded down
	localparam int PRECOMP_250_PS = 250000;
	localparam int PRECOMP_300_PS = 208300;
	localparam int PRECOMP_500_PS = 125000;
	localparam int PRECOMP_250_CYC = PRECOMP_250_PS / 20000;
	localparam int PRECOMP_300_CYC = PRECOMP_300_PS / 20000;
	localparam int PRECOMP_500_CYC = PRECOMP_500_PS / 20000;
	// Core clock toggles per 125 ref cycles (2.5 us) at 4.0/4.8/8.0 MHz
	localparam logic [7:0] FRAC_250_NUM = 8'h14;
	localparam logic [7:0] FRAC_300_NUM = 8'h18;
	localparam logic [7:0] FRAC_500_NUM = 8'h28;
	localparam logic [7:0] FRAC_DEN = 8'h7d;
	localparam int RQ_DMA_LEVEL = 2;
	localparam int RQ_IRQ_LEVEL = 6;

	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int MSR_READY_BIT = 7;
	localparam int MSR_DIR_BIT = 6;
	localparam int MSR_BUSY_BIT = 4;
	localparam int RATE_B0 = 0;
	localparam int RATE_B1 = 1;
	localparam int RESULT_BYTES = 3;

	// Data rate selection, from the two low control bits
	typedef enum logic [1:0] {
		RATE_500 = 2'b00,
		RATE_300 = 2'b01,
		RATE_250 = 2'b10,
		RATE_RSV = 2'b11
	} rate_e;

	// Command phase machine
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_EXEC,
		PH_RESULT
	} phase_e;

	// Event reports from the execution engine
	typedef struct packed {
		logic past_final_sector;
		logic id_crc_bad;
		logic data_crc_bad;
		logic sector_not_found;
		logic readid_fail;
		logic start_sector_missing;
		logic id_mark_missing;
		logic deleted_mark_seen;
		logic data_mark_missing;
		logic cyl_valid;
		logic [7:0] cyl_read;
		logic [7:0] cyl_req;
	} exec_events_s;

	// Drive lines as seen at the cable, active high
	typedef struct packed {
		logic drive_fault;
		logic write_protect;
		logic drive_ready_state;
		logic track_zero_state;
		logic double_sided_state;
		logic side_select_state;
		logic unit_sel_bit1_state;
		logic unit_sel_bit0_state;
	} drive_lines_s;

	// Operation class of the running command
	typedef struct packed {
		logic is_read;
		logic is_write;
		logic is_format;
		logic is_scan;
	} op_class_s;

endpackage

// ---- verilog/core_clock_gen.sv ----
// Glitch-free core clock generator for the three data rates
`timescale 1ns/1ps
module core_clock_gen (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Rate choice
	input wire logic [1:0] i_rate,
	// Core clock
	output logic o_core_clk
);

	logic [7:0] acc;
	logic [1:0] live_rate;
	logic [7:0] step;
	logic [8:0] acc_sum;
	logic phase_end;

	// Accumulator step for the rate now in force
	assign step = (live_rate == dskst_pkg::RATE_500) ?
		dskst_pkg::FRAC_500_NUM :
		(live_rate == dskst_pkg::RATE_300) ? dskst_pkg::FRAC_300_NUM :
		dskst_pkg::FRAC_250_NUM;
	assign acc_sum = {1'b0, acc} + {1'b0, step};
	// Toggle on each wrap; phases last 3 to 7 ref cycles, never under 60 ns
	assign phase_end = acc_sum >= {1'b0, dskst_pkg::FRAC_DEN};

	// Rate changes only at a phase end, so no phase is cut short
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			acc <= 8'h00;
			live_rate <= dskst_pkg::RATE_500;
			o_core_clk <= 1'b0;
		end else begin
			acc <= phase_end ? acc_sum[7:0] - dskst_pkg::FRAC_DEN :
				acc_sum[7:0];
			if (phase_end) begin
				o_core_clk <= ~o_core_clk;
				live_rate <= i_rate;
			end
		end
	end

endmodule

// ---- verilog/diskette_result_status.sv ----
// Diskette function status registers, host port and drive side lines
`timescale 1ns/1ps
module diskette_result_status (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Host I/O channel
	input wire logic [9:0] i_io_addr,
	input wire logic i_io_rd,
	input wire logic i_io_wr,
	input wire logic [7:0] i_io_wdata,
	output logic [7:0] o_io_rdata,
	output logic o_io_hit,
	// DMA and interrupt to the channel
	output logic o_dma_req_l2,
	input wire logic i_dma_ack_l2,
	output logic o_irq_l6,
	// Execution engine
	input wire logic i_exec_start,
	input wire logic i_exec_done,
	input wire dskst_pkg::op_class_s i_op,
	input wire dskst_pkg::exec_events_s i_ev,
	input wire logic i_byte_pending,
	input wire logic [7:0] i_cmd_opcode_unused,
	// Drive cable lines, raw
	input wire dskst_pkg::drive_lines_s i_drive,
	// Outputs to drive and core
	output logic o_reduced_write_current,
	output logic [7:0] o_drive_ctrl,
	output logic o_core_clk,
	output logic [7:0] o_precomp_cyc,
	// Status views
	output logic [7:0] o_status_one,
	output logic [7:0] o_status_two,
	output logic [7:0] o_snapshot
);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	dskst_pkg::drive_lines_s drv_meta;
	dskst_pkg::drive_lines_s drv_sync;

	// Two flops on the drive cable before any logic
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			drv_meta <= '0;
			drv_sync <= '0;
		end else begin
			drv_meta <= i_drive;
			drv_sync <= drv_meta;
		end
	end

	// ****************************************************************
	// Host decode
	// ****************************************************************
	logic sel_ctrl;
	logic sel_main;
	logic sel_data;
	logic sel_rate;
	logic wr_ctrl;
	logic wr_rate;
	logic rd_data;
	logic wr_data;
	assign sel_ctrl = i_io_addr == dskst_pkg::ADDR_OUTPUT_CTRL;
	assign sel_main = i_io_addr == dskst_pkg::ADDR_MAIN_STATE;
	assign sel_data = i_io_addr == dskst_pkg::ADDR_CMD_RESULT;
	assign sel_rate = i_io_addr == dskst_pkg::ADDR_RATE_INPUT;
	assign wr_ctrl = i_io_wr && sel_ctrl;
	assign wr_rate = i_io_wr && sel_rate;
	assign rd_data = i_io_rd && sel_data;
	assign wr_data = i_io_wr && sel_data;
	assign o_io_hit = sel_ctrl || sel_main || sel_data || sel_rate;

	// ****************************************************************
	// Control registers
	// ****************************************************************
	logic [7:0] drive_output_control;
	logic [7:0] rate_select_control;

	// Write-only control registers
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			drive_output_control <= dskst_pkg::RESET_BYTE;
			rate_select_control <= dskst_pkg::RESET_BYTE;
		end else begin
			if (wr_ctrl)
				drive_output_control <= i_io_wdata;
			if (wr_rate)
				rate_select_control <= i_io_wdata;
		end
	end

	logic [1:0] rate;
	assign rate = rate_select_control[dskst_pkg::RATE_B1:dskst_pkg::RATE_B0];
	assign o_drive_ctrl = drive_output_control;
	// Reduced write follows inverse of control bit 0
	assign o_reduced_write_current = ~rate_select_control[dskst_pkg::RATE_B0];

	// Core clock for the chosen rate
	core_clock_gen u_clk (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_rate(rate),
		.o_core_clk(o_core_clk)
	);

	// Precompensation and overrun limit per rate
	logic [15:0] ovr_limit;
	always_comb begin
		case (rate)
			dskst_pkg::RATE_500: begin
				ovr_limit = 16'(dskst_pkg::OVR_500_CYC);
				o_precomp_cyc = 8'(dskst_pkg::PRECOMP_500_CYC);
			end
			dskst_pkg::RATE_300: begin
				ovr_limit = 16'(dskst_pkg::OVR_300_CYC);
				o_precomp_cyc = 8'(dskst_pkg::PRECOMP_300_CYC);
			end
			default: begin
				ovr_limit = 16'(dskst_pkg::OVR_250_CYC);
				o_precomp_cyc = 8'(dskst_pkg::PRECOMP_250_CYC);
			end
		endcase
	end

	// ****************************************************************
	// Phase machine
	// ****************************************************************
	dskst_pkg::phase_e phase;
	dskst_pkg::phase_e next_phase;
	logic [1:0] res_idx;
	logic res_last;
	assign res_last = res_idx == 2'(dskst_pkg::RESULT_BYTES - 1);

	// Idle, execution, then result bytes read by the host
	always_comb begin
		next_phase = phase;
		case (phase)
			dskst_pkg::PH_IDLE:
				if (i_exec_start)
					next_phase = dskst_pkg::PH_EXEC;
			dskst_pkg::PH_EXEC:
				if (i_exec_done)
					next_phase = dskst_pkg::PH_RESULT;
			dskst_pkg::PH_RESULT:
				if (rd_data && res_last)
					next_phase = dskst_pkg::PH_IDLE;
			default:
				next_phase = dskst_pkg::PH_IDLE;
		endcase
	end

	logic enter_exec;
	logic enter_result;
	logic in_exec;
	assign enter_exec = phase == dskst_pkg::PH_IDLE && i_exec_start;
	assign enter_result = phase == dskst_pkg::PH_EXEC && i_exec_done;
	assign in_exec = phase == dskst_pkg::PH_EXEC;

	// Phase register and result byte index
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			phase <= dskst_pkg::PH_IDLE;
			res_idx <= 2'b00;
		end else begin
			phase <= next_phase;
			if (enter_result)
				res_idx <= 2'b00;
			else if (rd_data && phase == dskst_pkg::PH_RESULT)
				res_idx <= res_idx + 2'b01;
		end
	end

	// ****************************************************************
	// Overrun watchdog
	// ****************************************************************
	logic [15:0] svc_cnt;
	logic ovr_hit;
	logic svc_done;
	assign svc_done = i_dma_ack_l2 || rd_data || wr_data;
	assign ovr_hit = in_exec && i_byte_pending && svc_cnt >= ovr_limit;
	assign o_dma_req_l2 = in_exec && i_byte_pending;

	// Count cycles a transfer byte waits for service
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			svc_cnt <= 16'h0000;
		else if (!in_exec || !i_byte_pending || svc_done)
			svc_cnt <= 16'h0000;
		else if (!ovr_hit)
			svc_cnt <= svc_cnt + 16'h0001;
	end

	// ****************************************************************
	// Error flags
	// ****************************************************************
	logic f_end_of_cylinder;
	logic f_crc_failure;
	logic f_overrun;
	logic f_sector_missing;
	logic f_write_protected_hit;
	logic f_id_addr_absent;
	logic f_deleted_sector_seen;
	logic f_data_field_error;
	logic f_wrong_cylinder;
	logic f_bad_cylinder;
	logic f_data_addr_absent;

	logic ev_nd;
	logic ev_wc;
	logic ev_bc;
	logic ev_nw;
	logic ev_cm;
	logic cyl_diff;
	assign cyl_diff = i_ev.cyl_valid && i_ev.cyl_read != i_ev.cyl_req;
	// No-data from search failures
	assign ev_nd = i_ev.sector_not_found || i_ev.readid_fail ||
		i_ev.start_sector_missing || cyl_diff;
	assign ev_wc = cyl_diff;
	assign ev_bc = cyl_diff && i_ev.cyl_read == dskst_pkg::BAD_CYL_CODE;
	assign ev_nw = drv_sync.write_protect &&
		(i_op.is_write || i_op.is_format);
	assign ev_cm = i_ev.deleted_mark_seen &&
		(i_op.is_read || i_op.is_scan);

	// Sticky during execution; cleared on entry to execution
	always_ff @(posedge i_ref_clk) begin
		if (i_rst || enter_exec) begin
			f_end_of_cylinder <= 1'b0;
			f_crc_failure <= 1'b0;
			f_overrun <= 1'b0;
			f_sector_missing <= 1'b0;
			f_write_protected_hit <= 1'b0;
			f_id_addr_absent <= 1'b0;
			f_deleted_sector_seen <= 1'b0;
			f_data_field_error <= 1'b0;
			f_wrong_cylinder <= 1'b0;
			f_bad_cylinder <= 1'b0;
			f_data_addr_absent <= 1'b0;
		end else if (in_exec) begin
			f_end_of_cylinder <= f_end_of_cylinder ||
				i_ev.past_final_sector;
			f_crc_failure <= f_crc_failure || i_ev.id_crc_bad ||
				i_ev.data_crc_bad;
			f_overrun <= f_overrun || ovr_hit;
			f_sector_missing <= f_sector_missing || ev_nd;
			f_write_protected_hit <= f_write_protected_hit || ev_nw;
			f_id_addr_absent <= f_id_addr_absent ||
				i_ev.id_mark_missing;
			f_deleted_sector_seen <= f_deleted_sector_seen || ev_cm;
			f_data_field_error <= f_data_field_error ||
				i_ev.data_crc_bad;
			f_wrong_cylinder <= f_wrong_cylinder || ev_wc;
			f_bad_cylinder <= f_bad_cylinder || ev_bc;
			f_data_addr_absent <= f_data_addr_absent ||
				i_ev.id_mark_missing ||
				i_ev.data_mark_missing;
		end
	end

	// ****************************************************************
	// Status views
	// ****************************************************************
	// Unused positions are constant zero
	assign o_status_one = {f_end_of_cylinder, 1'b0, f_crc_failure,
		f_overrun, 1'b0, f_sector_missing, f_write_protected_hit,
		f_id_addr_absent};
	assign o_status_two = {1'b0, f_deleted_sector_seen, f_data_field_error,
		f_wrong_cylinder, 2'b00, f_bad_cylinder, f_data_addr_absent};
	// Live drive lines, fault down to unit select 0
	assign o_snapshot = {drv_sync.drive_fault, drv_sync.write_protect,
		drv_sync.drive_ready_state, drv_sync.track_zero_state,
		drv_sync.double_sided_state, drv_sync.side_select_state,
		drv_sync.unit_sel_bit1_state, drv_sync.unit_sel_bit0_state};

	// Main status: ready for host, direction, busy
	logic [7:0] main_state;
	assign main_state = {phase != dskst_pkg::PH_EXEC,
		phase == dskst_pkg::PH_RESULT, 1'b0, in_exec, 4'h0};

	logic [7:0] result_byte;
	assign result_byte = (res_idx == 2'b00) ? o_snapshot :
		(res_idx == 2'b01) ? o_status_one : o_status_two;

	logic [7:0] next_rdata;
	assign next_rdata = !i_io_rd ? o_io_rdata :
		sel_main ? main_state :
		(sel_data && phase == dskst_pkg::PH_RESULT) ? result_byte :
		sel_rate ? o_snapshot : dskst_pkg::RESET_BYTE;

	// Level-6 interrupt from result phase start, unshared
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_io_rdata <= dskst_pkg::RESET_BYTE;
			o_irq_l6 <= 1'b0;
		end else begin
			o_io_rdata <= next_rdata;
			if (enter_result)
				o_irq_l6 <= 1'b1;
			else if (rd_data)
				o_irq_l6 <= 1'b0;
		end
	end

endmodule

// ---- test/dskst_chk_assertions.sv ----
// Checker of the result status block port behaviour
`timescale 1ns/1ps
module dskst_chk (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Host, engine and drive inputs
	input wire logic [9:0] i_io_addr,
	input wire logic i_io_rd,
	input wire logic i_io_wr,
	input wire logic [7:0] i_io_wdata,
	input wire logic i_exec_start,
	input wire logic i_exec_done,
	input wire dskst_pkg::exec_events_s i_ev,
	input wire logic i_byte_pending,
	input wire dskst_pkg::drive_lines_s i_drive,
	// Outputs watched
	input wire logic o_dma_req_l2,
	input wire logic o_irq_l6,
	input wire logic o_reduced_write_current,
	input wire logic o_core_clk,
	input wire logic [7:0] o_precomp_cyc,
	input wire logic [7:0] o_status_one,
	input wire logic [7:0] o_status_two,
	input wire logic [7:0] o_snapshot
);
	// ********
	// Phase copy
	// ********
	logic [1:0] ph;
	logic [1:0] nrd;
	logic [1:0] age;
	wire data_rd = i_io_rd && i_io_addr == dskst_pkg::ADDR_CMD_RESULT;
	wire rate_wr = i_io_wr && i_io_addr == dskst_pkg::ADDR_RATE_INPUT;
	wire in_exec = ph == 2'h1;
	wire idle = ph == 2'h0;

	// Idle, exec, result; result ends after three data reads
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ph <= 2'h0;
			nrd <= 2'h0;
			age <= 2'h0;
		end else begin
			age <= age[1] ? age : age + 2'h1;
			if (idle && i_exec_start)
				ph <= 2'h1;
			if (in_exec && i_exec_done)
				ph <= 2'h2;
			if (ph == 2'h2 && data_rd)
				nrd <= nrd + 2'h1;
			if (ph == 2'h2 && data_rd && nrd == 2'h2) begin
				ph <= 2'h0;
				nrd <= 2'h0;
			end
		end
	end

	// Precompensation count for a rate code
	function automatic logic [7:0] pc(input logic [1:0] r);
		if (r == 2'h0)
			return 8'(dskst_pkg::PRECOMP_500_CYC);
		if (r == 2'h1)
			return 8'(dskst_pkg::PRECOMP_300_CYC);
		return 8'(dskst_pkg::PRECOMP_250_CYC);
	endfunction

	// ********
	// Properties
	// ********
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);
	sequence s_done;
		in_exec && i_exec_done;
	endsequence
	sequence s_rate;
		rate_wr;
	endsequence
	AST_IRQ_SET: assert property (s_done |=> o_irq_l6)
		else $error("interrupt not raised at result phase");
	AST_IRQ_CLR: assert property (o_irq_l6 && data_rd |=> !o_irq_l6)
		else $error("interrupt not cleared by data read");
	AST_DMA: assert property (
		o_dma_req_l2 == (in_exec && i_byte_pending)
	) else $error("dma request wrong");
	AST_RWC: assert property (
		s_rate |=> o_reduced_write_current == !$past(i_io_wdata[0])
	) else $error("reduced write current wrong");
	AST_PRECOMP: assert property (
		s_rate |=> o_precomp_cyc == pc($past(i_io_wdata[1:0]))
	) else $error("precompensation wrong");
	AST_SNAP: assert property (
		age[1] |-> o_snapshot == 8'($past(i_drive, 2))
	) else $error("snapshot wrong");
	AST_ZERO: assert property (
		!o_status_one[6] && !o_status_one[3] && !o_status_two[7]
	) else $error("unused status bit set");
	AST_CRC: assert property (
		in_exec && i_ev.data_crc_bad |=> o_status_one[5] && o_status_two[5]
	) else $error("data crc flags missing");
	AST_CYL: assert property (
		in_exec && i_ev.cyl_valid && i_ev.cyl_read == 8'hff &&
		i_ev.cyl_req != 8'hff |=> o_status_two[4] && o_status_two[1] &&
		o_status_one[2]
	) else $error("cylinder flags missing");
	AST_CLR: assert property (
		idle && i_exec_start |=> o_status_one == 8'h00 && o_status_two == 8'h00
	) else $error("flags not cleared at command start");
	AST_CLK: assert property ($changed(o_core_clk) |=> $stable(o_core_clk))
		else $error("core clock phase too short");
endmodule

bind diskette_result_status dskst_chk u_dskst_chk (.i_ref_clk, .i_rst,
	.i_io_addr, .i_io_rd, .i_io_wr, .i_io_wdata, .i_exec_start, .i_exec_done,
	.i_ev, .i_byte_pending, .i_drive, .o_dma_req_l2, .o_irq_l6,
	.o_reduced_write_current, .o_core_clk, .o_precomp_cyc, .o_status_one,
	.o_status_two, .o_snapshot);

// ---- test/drive_model.sv ----
// Behavioural diskette drive driving the cable status lines
`timescale 1ns/1ps
module drive_model (
	// Clock
	input wire logic i_clk,
	// Line levels commanded by the bench
	input wire logic [7:0] i_state,
	// Cable lines to the controller
	output dskst_pkg::drive_lines_s o_lines
);
	// Lines move a few ns after the edge, unrelated to sampling
	initial o_lines = '0;
	always @(posedge i_clk)
		o_lines <= #3 i_state;
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the diskette result status block
`timescale 1ns/1ps
module testbench;
	// ********
	// Signals
	// ********
	logic i_ref_clk;
	logic i_rst;
	logic [9:0] i_io_addr;
	logic i_io_rd;
	logic i_io_wr;
	logic [7:0] i_io_wdata;
	logic [7:0] o_io_rdata;
	logic o_io_hit;
	logic o_dma_req_l2;
	logic i_dma_ack_l2;
	logic o_irq_l6;
	logic i_exec_start;
	logic i_exec_done;
	dskst_pkg::op_class_s i_op;
	dskst_pkg::exec_events_s i_ev;
	logic i_byte_pending;
	dskst_pkg::drive_lines_s i_drive;
	logic o_reduced_write_current;
	logic [7:0] o_drive_ctrl;
	logic o_core_clk;
	logic [7:0] o_precomp_cyc;
	logic [7:0] o_status_one;
	logic [7:0] o_status_two;
	logic [7:0] o_snapshot;
	logic [7:0] dstate;
	logic [7:0] pc_exp [4];
	logic [31:0] seed;
	logic wp;
	logic pend;
	logic [15:0] e;
	logic [15:0] exp_q[$];
	int mismatches;
	int total_checks;
	logic last_ck;
	int edges;

	diskette_result_status u_diskette_result_status (.i_ref_clk, .i_rst,
		.i_io_addr, .i_io_rd, .i_io_wr, .i_io_wdata, .o_io_rdata, .o_io_hit,
		.o_dma_req_l2, .i_dma_ack_l2, .o_irq_l6, .i_exec_start, .i_exec_done,
		.i_op, .i_ev, .i_byte_pending, .i_cmd_opcode_unused(8'h00), .i_drive,
		.o_reduced_write_current, .o_drive_ctrl, .o_core_clk, .o_precomp_cyc,
		.o_status_one, .o_status_two, .o_snapshot);
	drive_model u_drive_model (.i_clk(i_ref_clk), .i_state(dstate),
		.o_lines(i_drive));

	// 50 MHz clock
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	// ********
	// Helpers
	// ********
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] g, input logic [7:0] x);
		total_checks++;
		if (g !== x) begin
			mismatches++;
			$display("Error %0t: got %h expected %h", $time, g, x);
		end
	endtask

	// One host access; a read notes its masked expectation
	task automatic io(input logic [9:0] a, input logic w, input logic [7:0] d,
		input logic [7:0] m);
		@(negedge i_ref_clk);
		i_io_addr = a;
		i_io_wr = w;
		i_io_rd = !w;
		i_io_wdata = d;
		if (!w)
			exp_q.push_back({m, d});
		@(negedge i_ref_clk);
		i_io_wr = 1'b0;
		i_io_rd = 1'b0;
	endtask

	// One command: start, events, byte wait, done, result reads
	task automatic run_cmd(input logic [3:0] op, input logic [25:0] ev,
		input int hold, input logic [7:0] e1, input logic [7:0] e2);
		seed = lfsr(seed);
		dstate = {seed[7], wp, seed[5:0]};
		@(negedge i_ref_clk);
		i_op = op;
		i_exec_start = 1'b1;
		@(negedge i_ref_clk);
		i_exec_start = 1'b0;
		i_ev = ev;
		i_byte_pending = hold > 0;
		@(negedge i_ref_clk);
		i_ev = '0;
		repeat (hold) @(negedge i_ref_clk);
		chk({7'h0, o_dma_req_l2}, {7'h0, hold > 0});
		i_byte_pending = 1'b0;
		i_dma_ack_l2 = hold > 0;
		@(negedge i_ref_clk);
		i_dma_ack_l2 = 1'b0;
		i_exec_done = 1'b1;
		@(negedge i_ref_clk);
		i_exec_done = 1'b0;
		chk({7'h0, o_irq_l6}, 8'h01);
		for (int k = 0; k < 3; k++) begin
			io(dskst_pkg::ADDR_MAIN_STATE, 1'b0, 8'hc0, 8'hc0);
			io(dskst_pkg::ADDR_CMD_RESULT, 1'b0,
				k == 0 ? dstate : k == 1 ? e1 : e2, 8'hff);
		end
		chk({7'h0, o_irq_l6}, 8'h00);
	endtask

	// Read data lands a cycle after the strobe; oldest note checked
	always @(posedge i_ref_clk)
		pend <= i_io_rd;
	always @(negedge i_ref_clk) begin
		if (pend) begin
			e = exp_q.pop_front();
			total_checks++;
			if ((o_io_rdata & e[15:8]) !== e[7:0]) begin
				mismatches++;
				$display("Error %0t: read %h expected %h", $time, o_io_rdata,
					e[7:0]);
			end
		end
	end

	// Cuts a hang short; the tests take some 1540 cycles
	initial begin
		repeat (20000) @(posedge i_ref_clk);
		mismatches++;
		end_sim;
	end

	// ********
	// Main sequence
	// ********
	initial begin
		i_rst = 1'b1;
		i_io_addr = 10'h000;
		i_io_rd = 1'b0;
		i_io_wr = 1'b0;
		i_io_wdata = 8'h00;
		i_dma_ack_l2 = 1'b0;
		i_exec_start = 1'b0;
		i_exec_done = 1'b0;
		i_op = '0;
		i_ev = '0;
		i_byte_pending = 1'b0;
		seed = 32'hb534;
		wp = 1'b0;
		dstate = 8'h00;
		pc_exp = '{8'(dskst_pkg::PRECOMP_500_CYC),
			8'(dskst_pkg::PRECOMP_300_CYC), 8'(dskst_pkg::PRECOMP_250_CYC),
			8'(dskst_pkg::PRECOMP_250_CYC)};
		repeat (6) @(negedge i_ref_clk);
		i_rst = 1'b0;
		repeat (3) @(negedge i_ref_clk);
		chk({7'h0, o_reduced_write_current}, 8'h01);
		chk(o_status_one, 8'h00);
		io(10'h3f0, 1'b0, 8'h00, 8'hff);
		chk({7'h0, o_io_hit}, 8'h00);
		io(dskst_pkg::ADDR_CMD_RESULT, 1'b0, 8'h00, 8'hff);
		// Drive output control takes a random byte and shows it
		seed = lfsr(seed);
		io(dskst_pkg::ADDR_OUTPUT_CTRL, 1'b1, seed[7:0], 8'h00);
		chk(o_drive_ctrl, seed[7:0]);
		chk({7'h0, o_io_hit}, 8'h01);
		// Every rate code, ending at the fastest rate
		for (int r = 3; r >= 0; r--) begin
			seed = lfsr(seed);
			dstate = seed[7:0];
			io(dskst_pkg::ADDR_RATE_INPUT, 1'b1, {seed[15:10], 2'(r)}, 8'h00);
			repeat (3) @(negedge i_ref_clk);
			chk({7'h0, o_reduced_write_current}, {7'h0, ~r[0]});
			chk(o_precomp_cyc, pc_exp[r]);
			chk(o_snapshot, dstate);
		end
		// Fastest rate: 8.0 MHz core clock makes 40 edges in 125 cycles
		repeat (5) @(negedge i_ref_clk);
		edges = 0;
		last_ck = o_core_clk;
		repeat (125) begin
			@(negedge i_ref_clk);
			edges += int'(o_core_clk !== last_ck);
			last_ck = o_core_clk;
		end
		chk(8'(edges), 8'h28);
		// Each condition alone; every row also shows the previous cleared
		run_cmd(4'h8, {10'h200, 16'h0}, 0, 8'h80, 8'h00);
		run_cmd(4'h8, {10'h100, 16'h0}, 0, 8'h20, 8'h00);
		run_cmd(4'h8, {10'h080, 16'h0}, 0, 8'h20, 8'h20);
		run_cmd(4'h1, {10'h040, 16'h0}, 0, 8'h04, 8'h00);
		run_cmd(4'h8, {10'h020, 16'h0}, 0, 8'h04, 8'h00);
		run_cmd(4'h8, {10'h010, 16'h0}, 0, 8'h04, 8'h00);
		run_cmd(4'h8, {10'h008, 16'h0}, 0, 8'h01, 8'h01);
		run_cmd(4'h1, {10'h004, 16'h0}, 0, 8'h00, 8'h40);
		run_cmd(4'h8, {10'h002, 16'h0}, 0, 8'h00, 8'h01);
		// Requested cylinder is the last of the supported tracks
		run_cmd(4'h8, {10'h001, 8'h05, 8'(dskst_pkg::MAX_TRACKS - 1)}, 0,
			8'h04, 8'h10);
		run_cmd(4'h8, {10'h001, 8'hff, 8'h07}, 0, 8'h04, 8'h12);
		run_cmd(4'h8, 26'h0, 600, 8'h10, 8'h00);
		run_cmd(4'h8, 26'h0, 500, 8'h00, 8'h00);
		// Write protect counts for write and format only
		wp = 1'b1;
		run_cmd(4'h4, 26'h0, 0, 8'h02, 8'h00);
		run_cmd(4'h2, 26'h0, 0, 8'h02, 8'h00);
		run_cmd(4'h8, 26'h0, 0, 8'h00, 8'h00);
		end_sim;
	end
endmodule
